/* File: logic/psw_regs.vh */
`ifndef PSW_REGS_VH
`define PSW_REGS_VH

// ****************************************************************
// Register addresses on the special function register port
// ****************************************************************
`define PSW_ADDR_INTERRUPT_ENABLE_PRIORITY_TWO 8'hA9
`define PSW_ADDR_CONV_START 8'hD8
`define PSW_ADDR_BAT_VALUE 8'hDF
`define PSW_ADDR_EVENT_ENABLE 8'hEC
`define PSW_ADDR_DELTA 8'hF3
`define PSW_ADDR_PERIPHERAL_CONFIG 8'hF4
`define PSW_ADDR_EVENT_FLAGS 8'hF8
`define PSW_ADDR_BAT_THRESH 8'hFA

// ****************************************************************
// Field positions
// ****************************************************************
`define PSW_BIT_MASTER_EN 1
`define PSW_BIT_SUP_LOW 0
`define PSW_BIT_SWITCHOVER 1
`define PSW_BIT_BAT_MON 2
`define PSW_BIT_SUP_ADC 3
`define PSW_BIT_SAG 5
`define PSW_BIT_RAIL_SRC 6
`define PSW_BIT_RESTORE 7

// Switchover source select codes
`define PSW_SRC_MAIN_LOW 2'h0
`define PSW_SRC_SUP_LOW 2'h1

// ****************************************************************
// Reset values
// ****************************************************************
`define PSW_RST_INTERRUPT_ENABLE_PRIORITY_TWO 8'h00
`define PSW_RST_CONV_START 8'h00
`define PSW_RST_BAT_VALUE 8'h00
`define PSW_RST_EVENT_ENABLE 8'h00
`define PSW_RST_DELTA 8'h00
`define PSW_RST_PERIPHERAL_CONFIG 8'h00
`define PSW_RST_EVENT_FLAGS 8'h00
`define PSW_RST_BAT_THRESH 8'h00

// ****************************************************************
// Timing
// ****************************************************************
`define PSW_CLK_HZ 20000000
`define PSW_MS_PER_S 1000
`define PSW_T_SWITCH_MS 8'h1E
`define PSW_T_RESTORE_MS 8'h82
`define PSW_T_SAMPLE_MS 8'h64

`endif

/* File: logic/psw_tick.v */
`include "psw_regs.vh"

// ****************************************************************
// Millisecond enable pulse divider
// ****************************************************************
module psw_tick #(
   parameter TICK_CYCLES = `PSW_CLK_HZ / `PSW_MS_PER_S
) (
   // Clock and reset
   input wire clk,
   input wire srst,
   // Enable pulse
   output reg tick
);

   reg [19:0] count;

   always @(posedge clk) begin
      if (srst) begin
         count <= 20'h00000;
         tick <= 1'b0;
      end else if (count == TICK_CYCLES[19:0] - 20'h00001) begin
         count <= 20'h00000;
         tick <= 1'b1;
      end else begin
         count <= count + 20'h00001;
         tick <= 1'b0;
      end
   end

endmodule

/* File: logic/psw_qualify.v */
`include "psw_regs.vh"

// ****************************************************************
// Condition qualifier: done once cond has held for LIMIT ticks
// ****************************************************************
module psw_qualify #(
   parameter [7:0] LIMIT = 8'h01
) (
   // Clock and reset
   input wire clk,
   input wire srst,
   // Millisecond enable and condition
   input wire tick,
   input wire cond,
   // Qualified condition
   output wire done
);

   reg [7:0] count;

   // Any drop of the condition restarts the wait
   always @(posedge clk) begin
      if (srst || !cond) begin
         count <= 8'h00;
      end else if (tick && count != LIMIT) begin
         count <= count + 8'h01;
      end
   end

   assign done = cond && (count == LIMIT);

endmodule

/* File: logic/psw_main.v */
// Behaviour
// - On battery, return to main only when all restore conditions hold, main above 2.75 V.
// - With supervisory source selected, return also needs supervisory input above 1.2 V.
// - With control pin enabled, return needs pin high plus a supply restore condition.
// - Shared power interrupt off after reset; master enable is bit 1 of register A9.
// - All power events share one interrupt; per-source enable register selects them.
// - Each flag stays set until software writes 0 to that bit.
// - Main to battery change sets switchover flag bit 1; enable bit 1 allows interrupt.
// - Battery to main change sets restore flag bit 7; enable bit 7 allows interrupt.
// - Switchover and restore flags set regardless of their enable bits.
// - Read-only bit 6 of peripheral config reads 1 on main, 0 on battery.
// - Supervisory reading changing more than delta threshold sets bit 3 interrupt source.
// - Supervisory input converted periodically and on conversion-start write; ready flagged.
// - Battery flag bit 2 set on reading below threshold or new result ready.
// - Supervisory low flag bit 0 set while input below 1.2 V; enable bit 0.
// - Sag flag bit 5 set on qualified line sag; enable bit 5.
// - Supervisory-low switchover happens about 30 ms after input falls below threshold.
// - After restore conditions met, rail returns to main after about 130 ms.
// - Source field 01 selects supervisory-low trigger, 00 selects main-supply-low trigger.
// - When enabled, falling edge on control pin switches to battery at any time.
// - Switchover disable bit keeps the rail on the main supply.
`include "psw_regs.vh"

module psw_main #(
   parameter TICK_CYCLES = `PSW_CLK_HZ / `PSW_MS_PER_S
) (
   // Clock and reset
   input wire clk,
   input wire srst,
   // Special function register port
   input wire [7:0] sfr_addr,
   input wire sfr_we,
   input wire sfr_re,
   input wire [7:0] sfr_wdata,
   output reg [7:0] sfr_rdata,
   // Comparator levels
   input wire main_supply_ok,
   input wire supervisory_input_ok,
   // Battery control pin and switchover configuration
   input wire battery_control_pin,
   input wire battery_control_enable,
   input wire [1:0] switchover_source_select,
   input wire switchover_disable,
   // Supervisory input converter
   output reg supervisory_conv_start,
   input wire supervisory_adc_done,
   input wire [7:0] supervisory_adc_result,
   output reg supervisory_result_ready,
   // Battery converter
   input wire battery_adc_done,
   input wire [7:0] battery_adc_result,
   // Sag detector event
   input wire sag_event,
   // Rail switch and interrupt
   output reg rail_on_main,
   output wire power_irq
);

   localparam ST_MAIN = 1'b0;
   localparam ST_BAT = 1'b1;

   // ****************************************************************
   // Address decode
   // ****************************************************************
   function hit;
      input [7:0] addr;
      input [7:0] offset;
      begin
         hit = (addr == offset);
      end
   endfunction

   // Configuration byte as read, with the live rail source in its read-only bit
   function [7:0] peripheral_config_view;
      input [7:0] cfg;
      input on_main;
      begin
         peripheral_config_view = cfg;
         peripheral_config_view[`PSW_BIT_RAIL_SRC] = on_main;
      end
   endfunction

   // ****************************************************************
   // Registers
   // ****************************************************************
   reg [7:0] interrupt_enable_priority_two;
   reg [7:0] conversion_start;
   reg [7:0] battery_adc_value;
   reg [7:0] power_event_enable;
   reg [7:0] delta_threshold;
   reg [7:0] peripheral_config;
   reg [7:0] power_event_flags;
   reg [7:0] battery_threshold;

   // ****************************************************************
   // Internal state
   // ****************************************************************
   wire [7:0] next_flags;
   reg [7:0] event_set;
   reg [7:0] last_supervisory;
   reg [7:0] delta;
   reg state;
   reg next_state;
   reg pin_prev;
   reg [7:0] sample_ms;

   wire tick;
   wire sup_low_qualified;
   wire restore_qualified;
   wire pin_fall;
   wire restore_cond;
   wire go_battery;
   wire to_battery;
   wire to_main;
   wire flag_write;
   genvar gi;

   // ****************************************************************
   // Timebase and qualifiers
   // ****************************************************************
   psw_tick #(
      .TICK_CYCLES(TICK_CYCLES)
   ) u_tick (
      .clk(clk),
      .srst(srst),
      .tick(tick)
   );

   psw_qualify #(
      .LIMIT(`PSW_T_SWITCH_MS)
   ) u_sup_low (
      .clk(clk),
      .srst(srst),
      .tick(tick),
      .cond(!supervisory_input_ok),
      .done(sup_low_qualified)
   );

   psw_qualify #(
      .LIMIT(`PSW_T_RESTORE_MS)
   ) u_restore (
      .clk(clk),
      .srst(srst),
      .tick(tick),
      .cond(restore_cond && state == ST_BAT),
      .done(restore_qualified)
   );

   // ****************************************************************
   // Rail source selection
   // ****************************************************************
   assign pin_fall = battery_control_enable && pin_prev && !battery_control_pin;

   // ****************************************************************
   // Restore and switchover conditions
   // ****************************************************************
   // Supply part of the restore condition depends on the selected source
   assign restore_cond = main_supply_ok
      && (switchover_source_select != `PSW_SRC_SUP_LOW || supervisory_input_ok)
      && (!battery_control_enable || battery_control_pin);

   assign go_battery = pin_fall
      || (switchover_source_select == `PSW_SRC_SUP_LOW && sup_low_qualified)
      || (switchover_source_select == `PSW_SRC_MAIN_LOW && !main_supply_ok);

   // ****************************************************************
   // Rail state machine
   // ****************************************************************
   always @* begin
      next_state = state;
      case (state)
         ST_MAIN: begin
            if (!switchover_disable && go_battery) begin
               next_state = ST_BAT;
            end
         end
         ST_BAT: begin
            if (switchover_disable) begin
               next_state = ST_MAIN;
            end else if (restore_qualified) begin
               next_state = ST_MAIN;
            end
         end
         default: begin
            next_state = ST_MAIN;
         end
      endcase
   end

   // ****************************************************************
   // Rail switch register
   // ****************************************************************
   assign to_battery = (state == ST_MAIN) && (next_state == ST_BAT);
   assign to_main = (state == ST_BAT) && (next_state == ST_MAIN);

   always @(posedge clk) begin
      if (srst) begin
         state <= ST_MAIN;
         rail_on_main <= 1'b1;
         pin_prev <= 1'b1;
      end else begin
         state <= next_state;
         rail_on_main <= (next_state == ST_MAIN);
         pin_prev <= battery_control_pin;
      end
   end

   // ****************************************************************
   // Supervisory conversions
   // ****************************************************************
   always @* begin
      if (supervisory_adc_result > last_supervisory) begin
         delta = supervisory_adc_result - last_supervisory;
      end else begin
         delta = last_supervisory - supervisory_adc_result;
      end
   end

   // ****************************************************************
   // Conversion scheduling
   // ****************************************************************
   always @(posedge clk) begin
      if (srst) begin
         sample_ms <= 8'h00;
         supervisory_conv_start <= 1'b0;
         supervisory_result_ready <= 1'b0;
         last_supervisory <= 8'h00;
      end else begin
         supervisory_conv_start <= 1'b0;
         if (tick) begin
            if (sample_ms == `PSW_T_SAMPLE_MS - 8'h01) begin
               sample_ms <= 8'h00;
               supervisory_conv_start <= 1'b1;
            end else begin
               sample_ms <= sample_ms + 8'h01;
            end
         end
         if (sfr_we && hit(sfr_addr, `PSW_ADDR_CONV_START)) begin
            supervisory_conv_start <= 1'b1;
         end
         if (supervisory_adc_done) begin
            supervisory_result_ready <= 1'b1;
            last_supervisory <= supervisory_adc_result;
         end else if (sfr_re && hit(sfr_addr, `PSW_ADDR_CONV_START)) begin
            supervisory_result_ready <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // Event flags
   // ****************************************************************
   always @* begin
      event_set = 8'h00;
      event_set[`PSW_BIT_SUP_LOW] = !supervisory_input_ok;
      event_set[`PSW_BIT_SWITCHOVER] = to_battery;
      event_set[`PSW_BIT_BAT_MON] = battery_adc_done
         || (battery_adc_value < battery_threshold);
      event_set[`PSW_BIT_SUP_ADC] = supervisory_adc_done
         && (delta > delta_threshold);
      event_set[`PSW_BIT_SAG] = sag_event;
      event_set[`PSW_BIT_RESTORE] = to_main;
   end

   // ****************************************************************
   // Flag update
   // ****************************************************************
   // Writing 0 clears a flag; a same-cycle event keeps it set
   assign flag_write = sfr_we && hit(sfr_addr, `PSW_ADDR_EVENT_FLAGS);

   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_flag
         assign next_flags[gi] = event_set[gi]
            || (power_event_flags[gi] && !(flag_write && !sfr_wdata[gi]));
      end
   endgenerate

   // ****************************************************************
   // Register writes
   // ****************************************************************
   always @(posedge clk) begin
      if (srst) begin
         interrupt_enable_priority_two <= `PSW_RST_INTERRUPT_ENABLE_PRIORITY_TWO;
         conversion_start <= `PSW_RST_CONV_START;
         battery_adc_value <= `PSW_RST_BAT_VALUE;
         power_event_enable <= `PSW_RST_EVENT_ENABLE;
         delta_threshold <= `PSW_RST_DELTA;
         peripheral_config <= `PSW_RST_PERIPHERAL_CONFIG;
         power_event_flags <= `PSW_RST_EVENT_FLAGS;
         battery_threshold <= `PSW_RST_BAT_THRESH;
      end else begin
         power_event_flags <= next_flags;
         if (battery_adc_done) begin
            battery_adc_value <= battery_adc_result;
         end
         if (sfr_we) begin
            if (hit(sfr_addr, `PSW_ADDR_INTERRUPT_ENABLE_PRIORITY_TWO)) begin
               interrupt_enable_priority_two <= sfr_wdata;
            end
            if (hit(sfr_addr, `PSW_ADDR_CONV_START)) begin
               conversion_start <= sfr_wdata;
            end
            if (hit(sfr_addr, `PSW_ADDR_EVENT_ENABLE)) begin
               power_event_enable <= sfr_wdata;
            end
            if (hit(sfr_addr, `PSW_ADDR_DELTA)) begin
               delta_threshold <= sfr_wdata;
            end
            if (hit(sfr_addr, `PSW_ADDR_PERIPHERAL_CONFIG)) begin
               peripheral_config <= sfr_wdata;
            end
            if (hit(sfr_addr, `PSW_ADDR_BAT_THRESH)) begin
               battery_threshold <= sfr_wdata;
            end
         end
      end
   end

   // ****************************************************************
   // Register reads
   // ****************************************************************
   always @(posedge clk) begin
      if (srst) begin
         sfr_rdata <= 8'h00;
      end else if (sfr_re) begin
         case (sfr_addr)
            `PSW_ADDR_INTERRUPT_ENABLE_PRIORITY_TWO: sfr_rdata <= interrupt_enable_priority_two;
            `PSW_ADDR_CONV_START: sfr_rdata <= conversion_start;
            `PSW_ADDR_BAT_VALUE: sfr_rdata <= battery_adc_value;
            `PSW_ADDR_EVENT_ENABLE: sfr_rdata <= power_event_enable;
            `PSW_ADDR_DELTA: sfr_rdata <= delta_threshold;
            `PSW_ADDR_PERIPHERAL_CONFIG: sfr_rdata <= peripheral_config_view(peripheral_config, rail_on_main);
            `PSW_ADDR_EVENT_FLAGS: sfr_rdata <= power_event_flags;
            `PSW_ADDR_BAT_THRESH: sfr_rdata <= battery_threshold;
            default: sfr_rdata <= 8'h00;
         endcase
      end
   end

   // ****************************************************************
   // Shared interrupt
   // ****************************************************************
   assign power_irq = interrupt_enable_priority_two[`PSW_BIT_MASTER_EN]
      && |(power_event_flags & power_event_enable);

endmodule

/* File: bench/psw_main_chk.sv */
module psw_main_chk (
   // Clock and reset
   input wire clk,
   input wire srst,
   // Observed ports
   input wire [7:0] sfr_addr,
   input wire sfr_we,
   input wire main_supply_ok,
   input wire supervisory_input_ok,
   input wire battery_control_pin,
   input wire battery_control_enable,
   input wire [1:0] switchover_source_select,
   input wire switchover_disable,
   input wire supervisory_conv_start,
   input wire supervisory_adc_done,
   input wire supervisory_result_ready,
   input wire rail_on_main,
   input wire power_irq
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   wire on_bat = !rail_on_main && !switchover_disable;
   wire sel_main = switchover_source_select == 2'h0;
   wire sel_sup = switchover_source_select == 2'h1;

   a_irq_reset_off: assert property (disable iff (1'b0) srst |=> !power_irq)
      else $error("interrupt high after reset");
   a_main_low_drop: assert property (
      rail_on_main && !switchover_disable && sel_main && !main_supply_ok |=> !rail_on_main)
      else $error("no switch on low main supply");
   a_pin_fall_drop: assert property (rail_on_main && !switchover_disable
      && battery_control_enable && $fell(battery_control_pin) |=> !rail_on_main)
      else $error("no switch on pin falling edge");
   a_main_bad_stay: assert property (on_bat && !main_supply_ok |=> !rail_on_main)
      else $error("returned with main supply low");
   a_sup_bad_stay: assert property (
      on_bat && sel_sup && !supervisory_input_ok |=> !rail_on_main)
      else $error("returned with supervisory input low");
   a_pin_low_stay: assert property (
      on_bat && battery_control_enable && !battery_control_pin |=> !rail_on_main)
      else $error("returned with control pin low");
   a_disable_main: assert property (switchover_disable |=> rail_on_main)
      else $error("rail left main while disabled");
   a_conv_on_write: assert property (
      sfr_we && sfr_addr == 8'hD8 |=> supervisory_conv_start)
      else $error("no conversion start after write");
   a_ready_on_done: assert property (
      supervisory_adc_done |=> supervisory_result_ready)
      else $error("result ready not set");
   a_restore_wait: assert property ($rose(rail_on_main)
      && !$past(switchover_disable) |-> $past(main_supply_ok, 8))
      else $error("restore without qualified main supply");

   c_drop: cover property ($fell(rail_on_main));
   c_back: cover property ($rose(rail_on_main));
   c_irq: cover property (power_irq);
endmodule

bind psw_main psw_main_chk chk (
   .clk(clk), .srst(srst), .sfr_addr(sfr_addr), .sfr_we(sfr_we),
   .main_supply_ok(main_supply_ok), .supervisory_input_ok(supervisory_input_ok),
   .battery_control_pin(battery_control_pin),
   .battery_control_enable(battery_control_enable),
   .switchover_source_select(switchover_source_select),
   .switchover_disable(switchover_disable),
   .supervisory_conv_start(supervisory_conv_start),
   .supervisory_adc_done(supervisory_adc_done),
   .supervisory_result_ready(supervisory_result_ready),
   .rail_on_main(rail_on_main), .power_irq(power_irq)
);

/* File: bench/psw_core_model.sv */
module psw_core_model (
   // Clock
   input wire clk,
   // Register port
   output logic [7:0] sfr_addr,
   output logic sfr_we,
   output logic sfr_re,
   output logic [7:0] sfr_wdata,
   input wire [7:0] sfr_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      sfr_addr = 8'h00;
      sfr_we = 1'b0;
      sfr_re = 1'b0;
      sfr_wdata = 8'h00;
   end
   // Event flags are cleared and conversions started through writes; a read of D8 clears ready
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_we = 1'b1;
      @(negedge clk);
      sfr_we = 1'b0;
      sfr_addr = ~a;
      sfr_wdata = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      sfr_addr = a;
      sfr_re = 1'b1;
      @(negedge clk);
      sfr_re = 1'b0;
      sfr_addr = ~a;
      @(negedge clk);
      d = sfr_rdata;
   endtask
endmodule

/* File: bench/tb_top.sv */
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, srst, main_ok, sup_ok, pin, pin_en, dis, sdone, bdone, sag;
   logic [1:0] src;
   logic [7:0] sres, bres;
   wire [7:0] sfr_addr, sfr_wdata, sfr_rdata;
   wire sfr_we, sfr_re, conv, ready, rail, irq;
   int error_cnt = 0;
   int checks = 0;
   logic [7:0] sres_tab [3] = '{8'h08, 8'h18, 8'h29};
   logic [7:0] flag_tab [3] = '{8'h00, 8'h00, 8'h08};

   psw_main #(.TICK_CYCLES(4)) uut (
      .clk(clk), .srst(srst), .sfr_addr(sfr_addr), .sfr_we(sfr_we), .sfr_re(sfr_re),
      .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .main_supply_ok(main_ok),
      .supervisory_input_ok(sup_ok), .battery_control_pin(pin),
      .battery_control_enable(pin_en), .switchover_source_select(src),
      .switchover_disable(dis), .supervisory_conv_start(conv),
      .supervisory_adc_done(sdone), .supervisory_adc_result(sres),
      .supervisory_result_ready(ready), .battery_adc_done(bdone),
      .battery_adc_result(bres), .sag_event(sag), .rail_on_main(rail), .power_irq(irq));
   psw_core_model core (.clk(clk), .sfr_addr(sfr_addr), .sfr_we(sfr_we),
      .sfr_re(sfr_re), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata));

   // ****************
   // Shared tasks
   // ****************
   task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %s exp %h got %h", nm, exp, got);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      core.rd(a, d);
      chk($sformatf("reg %h", a), d, e);
   endtask
   task automatic wait_rail(input logic v, input int lim, output int n);
      n = 0;
      while (rail !== v) begin
         @(negedge clk);
         n++;
         if (n > lim) begin
            error_cnt++;
            $display("BAD rail wait exp %h got %h", v, rail);
            wrap_up();
         end
      end
   endtask
   task automatic hold_rail(input logic v, input int cyc);
      logic ok;
      ok = 1'b1;
      repeat (cyc) begin
         @(negedge clk);
         if (rail !== v) ok = 1'b0;
      end
      chk("rail hold", ok, 1'b1);
   endtask

   // ****************
   // Scenarios
   // ****************
   task automatic t_regs();
      chk("irq", irq, 1'b0);
      rchk(8'hF8, 8'h00);
      rchk(8'hEC, 8'h00);
      rchk(8'hA9, 8'h00);
      rchk(8'hF4, 8'h40);
      rchk(8'hFA, 8'h00);
      core.wr(8'hDF, 8'h55);
      rchk(8'hDF, 8'h00);
      rchk(8'h10, 8'h00);
   endtask
   task automatic t_main();
      int n;
      main_ok = 0;
      wait_rail(0, 3, n);
      rchk(8'hF8, 8'h02);
      rchk(8'hF4, 8'h00);
      core.wr(8'hEC, 8'h02);
      chk("irq", irq, 1'b0);
      core.wr(8'hA9, 8'h02);
      chk("irq", irq, 1'b1);
      core.wr(8'hF8, 8'hFD);
      chk("irq", irq, 1'b0);
      main_ok = 1;
      wait_rail(1, 700, n);
      chk("restore time", n >= 500 && n <= 530, 1'b1);
      rchk(8'hF8, 8'h80);
      core.wr(8'hF8, 8'h00);
      core.wr(8'hEC, 8'h00);
   endtask
   task automatic t_sup();
      int n;
      src = 2'h1;
      sup_ok = 0;
      wait_rail(0, 200, n);
      chk("switch time", n >= 108 && n <= 126, 1'b1);
      rchk(8'hF8, 8'h03);
      hold_rail(0, 600);
      sup_ok = 1;
      main_ok = 0;
      hold_rail(0, 600);
      core.wr(8'hF8, 8'h00);
      main_ok = 1;
      wait_rail(1, 700, n);
      chk("restore time", n >= 500 && n <= 530, 1'b1);
      rchk(8'hF8, 8'h80);
      core.wr(8'hF8, 8'h00);
      src = 2'h0;
   endtask
   task automatic t_pin();
      int n;
      pin_en = 1;
      pin = 0;
      wait_rail(0, 3, n);
      hold_rail(0, 600);
      pin = 1;
      wait_rail(1, 700, n);
      pin_en = 0;
      main_ok = 0;
      wait_rail(0, 3, n);
      dis = 1;
      wait_rail(1, 3, n);
      hold_rail(1, 20);
      core.wr(8'hF8, 8'h00);
      rchk(8'hF8, 8'h00);
      main_ok = 1;
      dis = 0;
   endtask
   task automatic t_events();
      int n;
      core.wr(8'hF3, 8'h10);
      core.wr(8'hD8, 8'h00);
      n = 0;
      while (conv !== 1'b1 && n < 3) begin
         @(negedge clk);
         n++;
      end
      chk("conv start", conv, 1'b1);
      foreach (sres_tab[i]) begin
         sres = sres_tab[i];
         @(negedge clk) sdone = 1;
         @(negedge clk) sdone = 0;
         chk("ready", ready, 1'b1);
         rchk(8'hF8, flag_tab[i]);
      end
      rchk(8'hD8, 8'h00);
      chk("ready", ready, 1'b0);
      core.wr(8'hFA, 8'h20);
      bres = 8'h40;
      @(negedge clk) bdone = 1;
      @(negedge clk) bdone = 0;
      rchk(8'hF8, 8'h0C);
      rchk(8'hDF, 8'h40);
      core.wr(8'hF8, 8'h00);
      rchk(8'hF8, 8'h00);
      core.wr(8'hFA, 8'h50);
      rchk(8'hF8, 8'h04);
      @(negedge clk) sag = 1;
      @(negedge clk) sag = 0;
      rchk(8'hF8, 8'h24);
      core.wr(8'hEC, 8'h20);
      chk("irq", irq, 1'b1);
      core.wr(8'hF8, 8'h04);
      chk("irq", irq, 1'b0);
      core.wr(8'hA9, 8'h00);
      core.wr(8'hEC, 8'h24);
      chk("irq", irq, 1'b0);
   endtask
   initial begin
      clk = 0;
      forever #25 clk = ~clk;
   end
   initial begin
      srst = 1;
      {main_ok, sup_ok, pin} = 3'h7;
      {pin_en, dis, sdone, bdone, sag} = 5'h00;
      src = 2'h0;
      sres = 8'h00;
      bres = 8'h00;
      repeat (5) @(negedge clk);
      srst = 0;
      t_regs();
      t_main();
      t_sup();
      t_pin();
      t_events();
      wrap_up();
   end
endmodule
